// ### dv/serial_port_sva.sv
// bus handshake and line timing checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_out_pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // both write channels taken on one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_rd_unmapped: assert property (s_rd_taken ##0 (s_axi_araddr > 8'h0c)
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered wrongly");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_arready_pulse: assert property ($rose(s_axi_arready)
        |=> $fell(s_axi_arready)) else $error("arready not a pulse");
    a_rdata_upper: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    a_line_idle: assert property ($rose(rstn) |-> serial_out_pin)
        else $error("line not idle high after reset");
    a_bit_min: assert property ($changed(serial_out_pin)
        |=> $stable(serial_out_pin)[*8]) else $error("bit too short");
endmodule // serial_port_sva
bind serial_port serial_port_sva chk (.core_clk, .rstn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_out_pin);
`default_nettype wire

// ### dv/serial_port_tb.sv
// self-checking bench for the framed serial port
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
    logic core_clk, rstn, serial_in_pin, serial_out_pin, n9;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, d, c;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, mask, x;
    logic [3:0] s_axi_wstrb, uart_clk_en;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, m, src;
    logic [10:0] got;
    logic [7:0] rxc [9] = '{8'h4c, 8'h5e, 8'h74, 8'h7e, 8'hfe, 8'hf4,
        8'hd6, 8'hba, 8'h34};
    int bad_count, tests_run, dv, pr;
    integer seed = 32'h93a2467c;
    serial_port uut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_clk_en,
        .serial_in_pin, .serial_out_pin);
    uart_partner peer (.clk(core_clk), .line_out(serial_in_pin),
        .line_in(serial_out_pin));
    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // bit period in core cycles with every enable present
    function int per(logic [1:0] md, int div);
        return md == 2'b10 ? 16 : 16 * (div + 1);
    endfunction
    // expected line bits, start first
    function logic [10:0] frame(logic [1:0] md, logic [7:0] b, logic t9);
        return md == 2'b01 ? {2'b01, b, 1'b0} : {1'b1, t9, b, 1'b0};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($random(seed));
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($random(seed));
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    // hang guard
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        finish_test;
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h1;
        uart_clk_en = 4'hf;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // all registers clear after reset
        for (int i = 0; i < 16; i += 4) begin
            rd(i[7:0]);
            chk(rv, 32'h0);
        end
        // unmapped place refused
        wr(8'h20, 8'h5a);
        chk({30'h0, resp}, 32'h2);
        rd(8'h20);
        chk({rv[29:0], resp}, 32'h2);
        // a write with its low strobe off leaves the register alone
        s_axi_wstrb <= 4'h0;
        wr(8'h04, 8'h33);
        s_axi_wstrb <= 4'h1;
        rd(8'h04);
        chk(rv, 32'h0);
        // one transmitted frame per framed mode, random source and rate
        for (m = 2'b01; m != 2'b00; m++) begin
            src = $random(seed);
            dv = {$random(seed)} % 3;
            d = $random(seed);
            n9 = $random(seed);
            uart_clk_en <= 4'h1 << src;
            wr(8'h0c, {(m == 2'b01) ? 1'b0 : n9, 3'h0, src, 2'b00});
            wr(8'h04, dv[7:0]);
            wr(8'h08, {m, 2'b00, n9, 3'b000});
            fork
                wr(8'h00, d);
                peer.recv(per(m, dv), m == 2'b01 ? 10 : 11, got);
            join
            chk(got, frame(m, d, n9));
            repeat (4) @(posedge core_clk);
            rd(8'h08);
            chk(rv, {24'h0, m, 2'b00, n9, 3'b010});
        end
        // receive table: mode, filter, enable, bit 9, bit 10, flag
        uart_clk_en <= 4'hf;
        wr(8'h0c, 8'h00);
        wr(8'h04, 8'h01);
        for (int i = 0; i < 9; i++) begin
            c = rxc[i];
            m = c[7:6];
            d = $random(seed);
            pr = per(m, 1);
            wr(8'h08, {m, c[5:4], 4'h0});
            peer.send(pr, 10 + m[1], {c[2], c[3], d, 1'b0});
            mask = m == 2'b01 ? 32'hfb : 32'hff;
            rd(8'h08);
            x = {24'h0, m, c[5:4], 1'b0, c[3] & c[4], 1'b0, c[1]};
            chk(rv & mask, x & mask);
            if (c[1]) begin
                rd(8'h00);
                chk(rv, {24'h0, d});
            end
        end
        finish_test;
    end
endmodule // serial_port_tb
`default_nettype wire

// ### dv/uart_partner.sv
// far-end serial node that sends and captures frames
`timescale 1ns/1ps
`default_nettype none
module uart_partner (
    input wire logic clk,
    output logic line_out,
    input wire logic line_in
);
    // line idles high between frames
    initial line_out = 1'b1;
    // n bits lsb first, one period each, then an idle period
    task automatic send(input int per, input int n, input logic [10:0] v);
        for (int i = 0; i < n; i++) begin
            line_out <= v[i];
            repeat (per) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (per) @(posedge clk);
    endtask
    // sample n bits at mid-period after the falling start edge
    task automatic recv(input int per, input int n, output logic [10:0] v);
        v = 11'h0;
        @(negedge line_in);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            v[i] = line_in;
            repeat (per) @(posedge clk);
        end
    endtask
endmodule // uart_partner
`default_nettype wire

// ### hdl/serial_port.v
// framed asynchronous serial port with multiprocessor filter, axi4-lite regs
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port (
    input wire core_clk,
    input wire rstn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] uart_clk_en,
    input wire serial_in_pin,
    output reg serial_out_pin
);
    // state codes, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [7:0] shift_data_reg;
    reg [7:0] baud_divisor_reg;
    reg [7:0] port_ctrl_high;
    reg [7:0] port_ctrl_low;
    reg [7:0] aw_addr_r;
    reg aw_have_r;
    reg [7:0] w_data_r;
    reg w_strb_r;
    reg w_have_r;
    reg rx_s1_r;
    reg rx_s2_r;
    reg rx_prev_r;
    reg [7:0] baud_cnt_r;
    reg tick_r;
    reg [2:0] tx_st_r;
    reg [3:0] tx_ovs_r;
    reg [3:0] tx_cnt_r;
    reg [10:0] tx_sh_r;
    reg [2:0] rx_st_r;
    reg [3:0] rx_ovs_r;
    reg [3:0] rx_cnt_r;
    reg [8:0] rx_sh_r;
    reg tx_start_r;
    reg tx_done_r;
    reg rx_done_r;
    reg rx_nine_r;

    wire [1:0] mode = port_ctrl_high[`MODE_HI:`MODE_LO];
    wire is_nine = mode[1];
    wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
    wire clk_sel = uart_clk_en[port_ctrl_low[`CLK_HI:`CLK_LO]];
    wire [3:0] last_bit = is_nine ? `BITS_9 : `BITS_8;

    // decode a byte address to a register hit
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // oversampling tick: fixed divide in 9-bit fixed mode, else divisor
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            baud_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (clk_sel) begin
                if (mode == `MODE_9FIX ||
                    baud_cnt_r >= baud_divisor_reg) begin // no long wrap
                    baud_cnt_r <= 8'h00;
                    tick_r <= 1'b1;
                end else begin
                    baud_cnt_r <= baud_cnt_r + 8'h01;
                end
            end
        end
    end

    // two-stage synchroniser on the receive pin, plus a delayed copy for edges
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1; // idle level, so no false edge after reset
        end else begin
            rx_s1_r <= serial_in_pin;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end

    // axi4-lite write channel capture, either order
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_addr_r <= 8'h00;
            aw_have_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OK;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
                w_have_r <= 1'b1;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (hit(aw_addr_r, `OFS_DATA) ||
                    hit(aw_addr_r, `OFS_BAUD) || hit(aw_addr_r, `OFS_CTRLH) ||
                    hit(aw_addr_r, `OFS_CTRLL)) ? `RESP_OK : `RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file; hardware flag sets win over software clears
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_data_reg <= 8'h00;
            baud_divisor_reg <= 8'h00;
            port_ctrl_high <= 8'h00;
            port_ctrl_low <= 8'h00;
            tx_start_r <= 1'b0;
        end else begin
            tx_start_r <= 1'b0;
            if (do_wr && w_strb_r) begin
                if (hit(aw_addr_r, `OFS_DATA)) begin
                    shift_data_reg <= w_data_r;
                    tx_start_r <= 1'b1;
                end
                if (hit(aw_addr_r, `OFS_BAUD))
                    baud_divisor_reg <= w_data_r;
                if (hit(aw_addr_r, `OFS_CTRLH))
                    port_ctrl_high <= w_data_r;
                if (hit(aw_addr_r, `OFS_CTRLL))
                    port_ctrl_low <= w_data_r;
            end
            if (rx_done_r && !is_nine)
                port_ctrl_high[`BIT_RX9] <= rx_nine_r; // 8-bit: stop bit
            if (rx_st_r == ST_DONE) begin
                // 8 shifts leave the byte in [8:1], 9 shifts in [7:0]
                if (!is_nine)
                    shift_data_reg <= rx_sh_r[8:1];
                else
                    shift_data_reg <= rx_sh_r[7:0];
                if (is_nine)
                    port_ctrl_high[`BIT_RX9] <= rx_sh_r[8];
            end
            if (rx_done_r)
                port_ctrl_high[`BIT_RXP] <= 1'b1;
            if (tx_done_r)
                port_ctrl_high[`BIT_TXP] <= 1'b1;
        end
    end

    // axi4-lite read channel, one-cycle answer
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OK;
                s_axi_rdata <= 32'h00000000;
                if (hit(s_axi_araddr, `OFS_DATA))
                    s_axi_rdata[7:0] <= shift_data_reg;
                else if (hit(s_axi_araddr, `OFS_BAUD))
                    s_axi_rdata[7:0] <= baud_divisor_reg;
                else if (hit(s_axi_araddr, `OFS_CTRLH))
                    s_axi_rdata[7:0] <= port_ctrl_high;
                else if (hit(s_axi_araddr, `OFS_CTRLL))
                    s_axi_rdata[7:0] <= port_ctrl_low;
                else
                    s_axi_rresp <= `RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // transmitter: loads a framed word, shifts one bit per 16 ticks
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_r <= ST_IDLE;
            tx_ovs_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            tx_sh_r <= 11'h7ff;
            tx_done_r <= 1'b0;
            serial_out_pin <= 1'b1;
        end else begin
            tx_done_r <= 1'b0;
            case (tx_st_r)
                ST_IDLE: begin
                    serial_out_pin <= 1'b1;
                    if (tx_start_r && mode != `MODE_SYNC) begin
                        // stop, ninth, data, start; LSB goes first
                        if (is_nine)
                            tx_sh_r <= {1'b1, port_ctrl_high[`BIT_TX9],
                                shift_data_reg, 1'b0};
                        else
                            tx_sh_r <= {2'b11, shift_data_reg, 1'b0};
                        tx_ovs_r <= 4'h0;
                        tx_cnt_r <= 4'h0;
                        tx_st_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    serial_out_pin <= tx_sh_r[0];
                    if (tick_r) begin
                        tx_ovs_r <= tx_ovs_r + 4'h1;
                        if (tx_ovs_r == `OVS_LAST) begin
                            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                            if (tx_cnt_r == last_bit)
                                tx_st_r <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    serial_out_pin <= 1'b1;
                    tx_done_r <= 1'b1;
                    tx_st_r <= ST_IDLE;
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // receiver: start detect, mid-bit sampling, filter decision at stop
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_r <= ST_IDLE;
            rx_ovs_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 9'h000;
            rx_done_r <= 1'b0;
            rx_nine_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            case (rx_st_r)
                ST_IDLE: begin
                    rx_ovs_r <= 4'h0;
                    rx_cnt_r <= 4'h0;
                    // falling edge only: a low stop bit cannot restart us
                    if (port_ctrl_high[`BIT_RXEN] && mode != `MODE_SYNC &&
                        rx_prev_r && !rx_s2_r)
                        rx_st_r <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (tick_r) begin
                        rx_ovs_r <= rx_ovs_r + 4'h1;
                        if (rx_ovs_r == `OVS_MID) begin
                            rx_cnt_r <= rx_cnt_r + 4'h1;
                            if (rx_cnt_r == 4'h0) begin
                                if (rx_s2_r)
                                    rx_st_r <= ST_IDLE;
                            end else if (rx_cnt_r == last_bit) begin
                                // stop bit sampled: frame ends here
                                rx_st_r <= ST_DONE;
                                rx_nine_r <= rx_s2_r;
                            end else begin
                                rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
                            end
                        end
                    end
                end
                ST_DONE: begin
                    rx_st_r <= ST_IDLE;
                    if (is_nine) begin
                        // rx_sh_r[8] holds ninth bit after 9 shifts
                        if (!port_ctrl_high[`BIT_FILT] || rx_sh_r[8])
                            rx_done_r <= 1'b1;
                    end else if (!port_ctrl_high[`BIT_FILT] || rx_nine_r) begin
                        rx_done_r <= 1'b1;
                    end
                end
                default: rx_st_r <= ST_IDLE;
            endcase
        end
    end
endmodule // serial_port
`default_nettype wire

// ### hdl/serial_port_map.vh
// constants and register layout for the framed asynchronous serial port
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define OFS_DATA 8'h00
`define OFS_BAUD 8'h04
`define OFS_CTRLH 8'h08
`define OFS_CTRLL 8'h0c
`define MODE_HI 7
`define MODE_LO 6
`define BIT_FILT 5
`define BIT_RXEN 4
`define BIT_TX9 3
`define BIT_RX9 2
`define BIT_TXP 1
`define BIT_RXP 0
`define BIT_PAR 7
`define CLK_HI 3
`define CLK_LO 2
`define MODE_SYNC 2'b00
`define MODE_8VAR 2'b01
`define MODE_9FIX 2'b10
`define MODE_9VAR 2'b11
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define BITS_8 4'h9
`define BITS_9 4'ha
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif
